// ===== hw/cpgsc_pkg.sv
// constants, field layout and carrier types of the channel configuration bank
package cpgsc_pkg;

  localparam int NUM_CHANNELS = 8;
  localparam int FRAME_BITS   = 32;
  localparam int CH_W         = 3;

  // message frame layout
  localparam int RW_BIT = 31;
  localparam int ID_MSB = 30;
  localparam int ID_LSB = 27;
  localparam int CH_MSB = 26;
  localparam int CH_LSB = 24;

  localparam logic [3:0] MSG_PERIOD = 4'h1;
  localparam logic [3:0] MSG_GAIN   = 4'h2;
  localparam logic [3:0] MSG_SETP   = 4'h3;

  // period configuration fields
  localparam int SUMM_BIT = 16;
  localparam int DIVM_MSB = 15;
  localparam int DIVM_LSB = 14;
  localparam int DIVN_MSB = 13;
  localparam int DIVN_LSB = 0;

  // loop gain fields
  localparam int KP_MSB = 23;
  localparam int KP_LSB = 12;
  localparam int KI_MSB = 11;
  localparam int KI_LSB = 0;

  // setpoint and dither fields
  localparam int KEEP_BIT  = 23;
  localparam int DSTEP_MSB = 21;
  localparam int DSTEP_LSB = 11;
  localparam int SETP_MSB  = 10;
  localparam int SETP_LSB  = 0;

  // reset values
  localparam logic        SUMM_RST  = 1'b0;
  localparam logic [1:0]  DIVM_RST  = 2'h0;
  localparam logic [13:0] DIVN_RST  = 14'h0271;
  localparam logic [11:0] GAIN_RST  = 12'h000;
  localparam logic        KEEP_RST  = 1'b0;
  localparam logic [10:0] DSTEP_RST = 11'h000;
  localparam logic [10:0] SETP_RST  = 11'h000;

  // samples per period
  localparam logic [9:0] SPP_32  = 10'h020;
  localparam logic [9:0] SPP_64  = 10'h040;
  localparam logic [9:0] SPP_128 = 10'h080;
  localparam logic [9:0] SPP_512 = 10'h200;

  typedef struct packed {
    logic        sum_method;
    logic [1:0]  div_m;
    logic [13:0] div_n;
  } cpgsc_period_s;

  typedef struct packed {
    logic [11:0] kp;
    logic [11:0] ki;
  } cpgsc_gain_s;

  typedef struct packed {
    logic        keep_run;
    logic [10:0] dither_step;
    logic [10:0] setpoint;
  } cpgsc_setp_s;

  function automatic logic [9:0] samples_per_period(input logic [1:0] code, input logic direct_pwm);
    unique case (code)
      2'h0: samples_per_period = SPP_32;
      2'h1: samples_per_period = SPP_64;
      2'h2: samples_per_period = SPP_128;
      2'h3: samples_per_period = direct_pwm ? SPP_512 : SPP_128;
    endcase
  endfunction

endpackage

// ===== hw/cpgsc_period_timer.sv
// per-channel sample and period timing with sample substitution flag
`timescale 1ns/1ps
`default_nettype none
module cpgsc_period_timer (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire cpgsc_pkg::cpgsc_period_s cfg,
  input  wire logic                    direct_pwm_mode,
  input  wire logic                    out_edge,
  output var  logic                    adc_tick,
  output var  logic                    period_tick,
  output var  logic                    reuse_prev
);
  import cpgsc_pkg::*;

  logic [13:0] clk_cnt_reg;
  logic [9:0]  smp_cnt_reg;
  logic        discard_pend_reg;
  logic [9:0]  spp;
  logic        smp_done;

  assign spp      = samples_per_period(cfg.div_m, direct_pwm_mode);
  // a divider of zero behaves as one clock per sample
  assign smp_done = (clk_cnt_reg + 14'h0001 >= cfg.div_n);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      clk_cnt_reg <= 14'h0000;
    else if (smp_done)
      clk_cnt_reg <= 14'h0000;
    else
      clk_cnt_reg <= clk_cnt_reg + 14'h0001;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      smp_cnt_reg <= 10'h000;
      adc_tick    <= 1'b0;
      period_tick <= 1'b0;
    end
    else
    begin
      adc_tick    <= smp_done; // [RULE8]
      period_tick <= smp_done && (smp_cnt_reg + 10'h001 >= spp); // [RULE8]
      if (smp_done)
        smp_cnt_reg <= (smp_cnt_reg + 10'h001 >= spp) ? 10'h000 : smp_cnt_reg + 10'h001;
    end
  end

  // first sample after an output transition is replaced by the previous one
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      discard_pend_reg <= 1'b0;
      reuse_prev       <= 1'b0;
    end
    else
    begin
      reuse_prev <= smp_done && discard_pend_reg && cfg.sum_method; // [RULE5]
      if (out_edge && cfg.sum_method)
        discard_pend_reg <= 1'b1; // [RULE5]
      else if (smp_done || !cfg.sum_method)
        discard_pend_reg <= 1'b0; // [RULE4]
    end
  end

endmodule
`default_nettype wire

// ===== hw/cpgsc_config_bank.sv
// serial-accessed per-channel period, gain and setpoint configuration bank
//
// Contract
// [RULE1] Bit 31 of a sent message: 0 reads the setting, 1 writes it.
// [RULE2] Period message has identifier 0001 in 30:27, channel in 26:24.
// [RULE3] Period response: bit31 zero, echoed id and channel, 23:17 zero, stored fields.
// [RULE4] Summation method 0, the reset value, averages every sample in the period.
// [RULE5] Summation method 1 drops first sample after output transition, reuses previous.
// [RULE6] Samples per period code: 32, 64, 128, or 512 direct / 128 current mode.
// [RULE7] Fourteen-bit clocks per sample in 13:0, resetting to 625.
// [RULE8] Period equals clocks per sample times samples per period clock periods.
// [RULE9] Gain message has identifier 0010, channel in 26:24, direction bit 31.
// [RULE10] Proportional gain stored from 23:12, resetting to zero.
// [RULE11] Integral gain stored from 11:0, resetting to zero.
// [RULE12] Gain response: bit31 zero, echoed id and channel, stored gains in place.
// [RULE13] Setpoint message has identifier 0011; eleven-bit setpoint in 10:0, reset zero.
// [RULE14] Bit 23 zero disables channel with enable; one keeps it running.
// [RULE15] Eleven-bit dither step stored from 21:11, reset zero, quarter setpoint LSB.
// [RULE16] Dither step of zero turns dither off for that channel.
// [RULE17] Writes touch only the addressed channel; unused sent bits are ignored.
`timescale 1ns/1ps
`default_nettype none
module cpgsc_config_bank #(
  parameter int NCH = cpgsc_pkg::NUM_CHANNELS
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire logic                     spi_sclk,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spi_mosi,
  output var  logic                     spi_miso,
  output var  logic                     spi_miso_oe_n,
  input  wire logic                     enable_pin,
  input  wire logic                     direct_pwm_mode,
  input  wire logic [NCH-1:0]           channel_output_pin,
  output var  cpgsc_pkg::cpgsc_period_s period_cfg [NCH],
  output var  cpgsc_pkg::cpgsc_gain_s   gain_cfg [NCH],
  output var  cpgsc_pkg::cpgsc_setp_s   setp_cfg [NCH],
  output var  logic [NCH-1:0]           channel_run,
  output var  logic [NCH-1:0]           dither_active,
  output var  logic [NCH-1:0]           adc_sample_tick,
  output var  logic [NCH-1:0]           pwm_period_tick,
  output var  logic [NCH-1:0]           sample_reuse_prev,
  output var  logic                     frame_error
);
  import cpgsc_pkg::*;

  if (NCH != NUM_CHANNELS)
  begin : g_bad_nch
    $error("channel count must match the 3-bit channel field");
  end

  typedef enum logic [0:0] {
    LINK_IDLE,
    LINK_SHIFT
  } cpgsc_link_e;

  // pin synchronisers
  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic [1:0] en_sync_reg;
  logic [NCH-1:0] outp_meta_reg;
  logic [NCH-1:0] outp_sync_reg;
  logic [NCH-1:0] outp_prev_reg;
  logic       sclk_prev_reg;
  logic       cs_prev_reg;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
      en_sync_reg   <= 2'h0;
      outp_meta_reg <= '0;
      outp_sync_reg <= '0;
      outp_prev_reg <= '0;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], spi_sclk};
      cs_sync_reg   <= {cs_sync_reg[0], spi_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
      en_sync_reg   <= {en_sync_reg[0], enable_pin};
      outp_meta_reg <= channel_output_pin;
      outp_sync_reg <= outp_meta_reg;
      outp_prev_reg <= outp_sync_reg;
      sclk_prev_reg <= sclk_sync_reg[1];
      cs_prev_reg   <= cs_sync_reg[1];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] && !sclk_prev_reg;
  assign sclk_fall = !sclk_sync_reg[1] && sclk_prev_reg;
  assign cs_fall   = !cs_sync_reg[1] && cs_prev_reg;
  assign cs_rise   = cs_sync_reg[1] && !cs_prev_reg;

  // frame shifter
  cpgsc_link_e link_state_reg;
  logic [FRAME_BITS-1:0] rx_reg;
  logic [FRAME_BITS-1:0] tx_reg;
  logic [FRAME_BITS-1:0] resp_reg;
  logic [5:0]            bit_cnt_reg;
  logic                  frame_done_reg;
  logic                  resp_load_reg;
  logic [3:0]            last_id_reg;
  logic [CH_W-1:0]       last_ch_reg;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link_state_reg <= LINK_IDLE;
      rx_reg         <= '0;
      bit_cnt_reg    <= 6'h00;
      frame_done_reg <= 1'b0;
      frame_error    <= 1'b0;
    end
    else
    begin
      frame_done_reg <= 1'b0;
      frame_error    <= 1'b0;
      unique case (link_state_reg)
        LINK_IDLE:
        begin
          if (cs_fall)
          begin
            link_state_reg <= LINK_SHIFT;
            bit_cnt_reg    <= 6'h00;
          end
        end
        LINK_SHIFT:
        begin
          if (cs_rise)
          begin
            link_state_reg <= LINK_IDLE;
            // only whole frames are acted on
            if (bit_cnt_reg == 6'(FRAME_BITS))
              frame_done_reg <= 1'b1;
            else
              frame_error <= 1'b1;
          end
          else if (sclk_rise)
          begin
            rx_reg <= {rx_reg[FRAME_BITS-2:0], mosi_sync_reg[1]};
            if (bit_cnt_reg != 6'h3f)
              bit_cnt_reg <= bit_cnt_reg + 6'h01;
          end
        end
      endcase
    end
  end

  // answer of a frame leaves during the following frame
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      tx_reg <= '0;
    else if (cs_fall)
      tx_reg <= resp_reg;
    else if (link_state_reg == LINK_SHIFT && sclk_fall)
      tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
  end

  assign spi_miso      = tx_reg[FRAME_BITS-1];
  assign spi_miso_oe_n = cs_sync_reg[1];

  // decoded fields of the received frame
  logic            wr_req;
  logic [3:0]      msg_ident;
  logic [CH_W-1:0] msg_ch;

  assign wr_req = rx_reg[RW_BIT]; // [RULE1]
  assign msg_ident = rx_reg[ID_MSB:ID_LSB]; // [RULE2] [RULE9] [RULE13]
  assign msg_ch = rx_reg[CH_MSB:CH_LSB];

  function automatic logic hit(input logic [3:0] id, input logic [CH_W-1:0] ch, input int idx);
    hit = (id == msg_ident) && (ch == CH_W'(idx));
  endfunction

  // period configuration storage
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        period_cfg[i].sum_method <= SUMM_RST; // [RULE4]
        period_cfg[i].div_m <= DIVM_RST; // [RULE6]
        period_cfg[i].div_n <= DIVN_RST; // [RULE7]
      end
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (frame_done_reg && wr_req && hit(MSG_PERIOD, msg_ch, i)) // [RULE17]
        begin
          period_cfg[i].sum_method <= rx_reg[SUMM_BIT]; // [RULE4] [RULE5]
          period_cfg[i].div_m <= rx_reg[DIVM_MSB:DIVM_LSB]; // [RULE6]
          period_cfg[i].div_n <= rx_reg[DIVN_MSB:DIVN_LSB]; // [RULE7]
        end
      end
    end
  end

  // loop gain storage
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        gain_cfg[i].kp <= GAIN_RST;
        gain_cfg[i].ki <= GAIN_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (frame_done_reg && wr_req && hit(MSG_GAIN, msg_ch, i)) // [RULE17]
        begin
          gain_cfg[i].kp <= rx_reg[KP_MSB:KP_LSB]; // [RULE10]
          gain_cfg[i].ki <= rx_reg[KI_MSB:KI_LSB]; // [RULE11]
        end
      end
    end
  end

  // setpoint and dither storage; bit 22 is ignored
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        setp_cfg[i].keep_run    <= KEEP_RST;
        setp_cfg[i].dither_step <= DSTEP_RST;
        setp_cfg[i].setpoint    <= SETP_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (frame_done_reg && wr_req && hit(MSG_SETP, msg_ch, i)) // [RULE17]
        begin
          setp_cfg[i].keep_run    <= rx_reg[KEEP_BIT]; // [RULE14]
          setp_cfg[i].dither_step <= rx_reg[DSTEP_MSB:DSTEP_LSB]; // [RULE15]
          setp_cfg[i].setpoint    <= rx_reg[SETP_MSB:SETP_LSB]; // [RULE13]
        end
      end
    end
  end

  // response is built one cycle later, after any write has landed
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      resp_load_reg <= 1'b0;
      last_id_reg   <= 4'h0;
      last_ch_reg   <= '0;
    end
    else
    begin
      resp_load_reg <= frame_done_reg;
      if (frame_done_reg)
      begin
        last_id_reg <= msg_ident;
        last_ch_reg <= msg_ch;
      end
    end
  end

  logic [23:0] resp_data;

  always_comb
  begin
    resp_data = 24'h000000;
    unique case (last_id_reg)
      MSG_PERIOD:
        resp_data = {7'h00, period_cfg[last_ch_reg]}; // [RULE3]
      MSG_GAIN:
        resp_data = {gain_cfg[last_ch_reg].kp, gain_cfg[last_ch_reg].ki}; // [RULE12]
      MSG_SETP:
        resp_data = {setp_cfg[last_ch_reg].keep_run, 1'b0,
                     setp_cfg[last_ch_reg].dither_step, setp_cfg[last_ch_reg].setpoint};
      default:
        resp_data = 24'h000000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      resp_reg <= '0;
    else if (resp_load_reg)
      resp_reg <= {1'b0, last_id_reg, last_ch_reg, resp_data}; // [RULE3] [RULE12]
  end

  // channel run and dither qualifiers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      channel_run   <= '0;
      dither_active <= '0;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        channel_run[i]   <= en_sync_reg[1] || setp_cfg[i].keep_run; // [RULE14]
        dither_active[i] <= (setp_cfg[i].dither_step != DSTEP_RST); // [RULE16]
      end
    end
  end

  // per-channel sample timing
  for (genvar g = 0; g < NCH; g++)
  begin : g_timer
    cpgsc_period_timer u_timer (
      .sys_clk         (sys_clk),
      .rstn            (rstn),
      .cfg             (period_cfg[g]),
      .direct_pwm_mode (direct_pwm_mode), // [RULE6]
      .out_edge        (outp_sync_reg[g] ^ outp_prev_reg[g]), // [RULE5]
      .adc_tick        (adc_sample_tick[g]),
      .period_tick     (pwm_period_tick[g]),
      .reuse_prev      (sample_reuse_prev[g])
    );
  end

endmodule
`default_nettype wire

// ===== verif/cpgsc_monitor.sv
// assertion checker for the channel configuration bank
`timescale 1ns/1ps
`default_nettype none
module cpgsc_monitor #(
  parameter int NCH = cpgsc_pkg::NUM_CHANNELS
) (
  input wire logic                     sys_clk,
  input wire logic                     rstn,
  input wire logic                     enable_pin,
  input wire logic                     direct_pwm_mode,
  input wire logic [NCH-1:0]           channel_output_pin,
  input wire cpgsc_pkg::cpgsc_period_s period_cfg [NCH],
  input wire cpgsc_pkg::cpgsc_setp_s   setp_cfg [NCH],
  input wire logic [NCH-1:0]           channel_run,
  input wire logic [NCH-1:0]           dither_active,
  input wire logic [NCH-1:0]           adc_sample_tick,
  input wire logic [NCH-1:0]           pwm_period_tick,
  input wire logic [NCH-1:0]           sample_reuse_prev
);
  import cpgsc_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic [14:0] gap;
  logic [9:0]  nt;
  logic [13:0] nx;
  logic [9:0]  mx;
  logic        seen, dirty, pseen, pdirty;
  assign nx = (period_cfg[0].div_n == 14'h0) ? 14'h1 : period_cfg[0].div_n;
  assign mx = (period_cfg[0].div_m == 2'h0) ? 10'h020 : (period_cfg[0].div_m == 2'h1) ? 10'h040 :
              (period_cfg[0].div_m == 2'h3 && direct_pwm_mode) ? 10'h200 : 10'h080;
  // interval counters; dirty marks intervals spoilt by a config change
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap    <= '0;
      nt     <= '0;
      seen   <= 1'b0;
      dirty  <= 1'b0;
      pseen  <= 1'b0;
      pdirty <= 1'b0;
    end
    else
    begin
      gap    <= adc_sample_tick[0] ? 15'h1 : gap + 15'h1;
      nt     <= pwm_period_tick[0] ? 10'h0 : nt + 10'(adc_sample_tick[0]);
      seen   <= seen | adc_sample_tick[0];
      pseen  <= pseen | pwm_period_tick[0];
      dirty  <= $changed(period_cfg[0]) || (dirty && !adc_sample_tick[0]);
      pdirty <= $changed(period_cfg[0]) || $changed(direct_pwm_mode) || (pdirty && !pwm_period_tick[0]);
    end
  end
  sequence s_pin_edge;
    $changed(channel_output_pin[0]) && period_cfg[0].sum_method && period_cfg[0].div_n < 14'h8;
  endsequence
  sequence s_setp_still;
    $stable(setp_cfg[0]) [*2];
  endsequence
  AST_DITHER_LEVEL: assert property (
    s_setp_still |-> dither_active[0] == (setp_cfg[0].dither_step != 11'h0)) else $error("dither flag wrong");
  AST_KEEP_RUN: assert property (
    (setp_cfg[0].keep_run && $stable(setp_cfg[0].keep_run)) [*2] |-> channel_run[0]) else $error("run dropped");
  AST_STOP_RUN: assert property (
    (!enable_pin && !setp_cfg[0].keep_run) [*5] |-> !channel_run[0]) else $error("run not stopped");
  AST_ADC_SPACING: assert property (
    adc_sample_tick[0] && seen && !dirty && $stable(period_cfg[0]) |-> gap == 15'(nx)) else $error("sample gap");
  AST_PERIOD_ON_SAMPLE: assert property (
    pwm_period_tick[0] |-> adc_sample_tick[0]) else $error("period tick off sample");
  AST_PERIOD_COUNT: assert property (
    pwm_period_tick[0] && pseen && !pdirty && $stable(period_cfg[0]) && $stable(direct_pwm_mode)
    |-> nt + 10'h1 == mx) else $error("samples per period");
  AST_REUSE_NEEDS_METHOD: assert property (
    sample_reuse_prev[0] |-> adc_sample_tick[0] && (period_cfg[0].sum_method || $past(period_cfg[0].sum_method)))
    else $error("reuse without method");
  AST_REUSE_AFTER_EDGE: assert property (
    s_pin_edge |-> ##[1:24] sample_reuse_prev[0]) else $error("no reuse after edge");
endmodule
bind cpgsc_config_bank cpgsc_monitor #(.NCH(NCH)) cpgsc_monitor_i (
  .sys_clk, .rstn, .enable_pin, .direct_pwm_mode, .channel_output_pin, .period_cfg, .setp_cfg,
  .channel_run, .dither_active, .adc_sample_tick, .pwm_period_tick, .sample_reuse_prev
);
`default_nettype wire

// ===== verif/cpgsc_host_model.sv
// serial host model shifting whole or truncated frames of a given bit count into the bank
`timescale 1ns/1ps
`default_nettype none
module cpgsc_host_model (
  input  wire logic        sys_clk,
  input  wire logic        spi_miso,
  input  wire logic        spi_miso_oe_n,
  output var  logic        spi_sclk,
  output var  logic        spi_cs_n,
  output var  logic        spi_mosi,
  output var  logic [31:0] rx_word,
  output var  logic        rx_done
);
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rx_word  = '0;
    rx_done  = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // half link period is 8 clocks; a released miso reads unknown
  task automatic xfer(input logic [31:0] tx, input int nb);
    logic [31:0] rx;
    rx = 'x;
    hold(1);
    spi_cs_n = 1'b0;
    for (int i = 31; i > 31 - nb; i--)
    begin
      spi_mosi = tx[i];
      hold(8);
      rx[i] = spi_miso_oe_n ? 1'bx : spi_miso;
      spi_sclk = 1'b1;
      hold(8);
      spi_sclk = 1'b0;
    end
    hold(8);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    rx_word = rx;
    rx_done = 1'b1;
    hold(1);
    rx_done = 1'b0;
    hold(12);
  endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the channel configuration bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cpgsc_pkg::*;
  logic          sys_clk = 1'b0, rstn = 1'b0, enable_pin = 1'b0, direct_pwm_mode = 1'b0;
  logic [7:0]    channel_output_pin = 8'h00;
  logic          spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, frame_error, rx_done;
  logic [7:0]    channel_run, dither_active, adc_sample_tick, pwm_period_tick, sample_reuse_prev;
  logic [31:0]   rx_word;
  logic [32:0]   last, note;
  logic [32:0]   q [$];
  cpgsc_period_s period_cfg [8], sp [8];
  cpgsc_gain_s   gain_cfg [8], sg [8];
  cpgsc_setp_s   setp_cfg [8], ss [8];
  int            failures = 0, samples_checked = 0, ferr = 0;
  int            mt [5] = '{32, 64, 128, 128, 512};
  integer        seed = 40948;
  always #5 sys_clk = ~sys_clk;
  cpgsc_config_bank cpgsc_config_bank_i (
    .sys_clk, .rstn, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n, .enable_pin,
    .direct_pwm_mode, .channel_output_pin, .period_cfg, .gain_cfg, .setp_cfg, .channel_run,
    .dither_active, .adc_sample_tick, .pwm_period_tick, .sample_reuse_prev, .frame_error
  );
  cpgsc_host_model cpgsc_host_model_i (
    .sys_clk, .spi_miso, .spi_miso_oe_n, .spi_sclk, .spi_cs_n, .spi_mosi, .rx_word, .rx_done
  );
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmp_resp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cfg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: setting %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] resp(input logic [3:0] id, input logic [2:0] ch);
    case (id)
      4'h1: resp = {1'b0, id, ch, 7'h00, sp[ch]};
      4'h2: resp = {1'b0, id, ch, sg[ch]};
      4'h3: resp = {1'b0, id, ch, ss[ch].keep_run, 1'b0, ss[ch].dither_step, ss[ch].setpoint};
      default: resp = {1'b0, id, ch, 24'h000000};
    endcase
  endfunction
  // notes the answer due in this frame, which is the previous frame's
  task automatic op(input logic w, input logic [3:0] id, input logic [2:0] ch, input logic [23:0] d, input int nb);
    q.push_back(nb == 32 ? last : 33'h0);
    cpgsc_host_model_i.xfer({w, id, ch, d}, nb);
    if (nb == 32)
    begin
      if (w && id == 4'h1) sp[ch] = d[16:0];
      if (w && id == 4'h2) sg[ch] = d;
      if (w && id == 4'h3) ss[ch] = {d[23], d[21:0]};
      last = {1'b1, resp(id, ch)};
    end
  endtask
  task automatic chk;
    for (int c = 0; c < 8; c++)
    begin
      cmp_cfg(32'(period_cfg[c]), 32'(sp[c]));
      cmp_cfg(32'(gain_cfg[c]), 32'(sg[c]));
      cmp_cfg(32'(setp_cfg[c]), 32'(ss[c]));
      cmp_cfg(32'(channel_run[c]), 32'(enable_pin | ss[c].keep_run));
      cmp_cfg(32'(dither_active[c]), 32'(ss[c].dither_step != 11'h0));
    end
  endtask
  task automatic period_len(input int exp);
    int n;
    for (n = 0; n < 9000 && pwm_period_tick[0] !== 1'b1; n++) hold(1);
    for (n = 1; n < 9000; n++)
    begin
      hold(1);
      if (pwm_period_tick[0] === 1'b1) break;
    end
    cmp_cfg(32'(n), 32'(exp));
    if (n >= 9000) finish_test;
  endtask
  always @(posedge sys_clk)
    if (rx_done === 1'b1 && q.size() > 0)
    begin
      note = q.pop_front();
      if (note[32]) cmp_resp(rx_word, note[31:0]);
    end
  always @(posedge sys_clk)
    if (frame_error === 1'b1) ferr++;
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    finish_test;
  end
  initial
  begin
    for (int c = 0; c < 8; c++)
    begin
      sp[c] = {1'b0, 2'h0, 14'h0271};
      sg[c] = '0;
      ss[c] = '0;
    end
    last = 33'h0;
    hold(5);
    rstn = 1'b1;
    hold(4);
    chk;
    for (int i = 0; i < 16; i++) op(1'b0, 4'(i), 3'(i), 24'($random(seed)), 32);
    $display("test reset_read done");
    op(1'b1, 4'h3, 3'h0, 24'hffffff, 32);
    chk;
    op(1'b1, 4'h3, 3'h0, 24'h400000, 32);
    hold(6);
    chk;
    $display("test keep_run done");
    for (int k = 0; k < 40; k++)
    begin
      enable_pin = 1'($random(seed));
      op(1'($random(seed)), 4'($random(seed)), 3'($random(seed)), 24'($random(seed)), 32);
      if (k % 8 == 7) chk;
    end
    $display("test random_access done");
    for (int i = 0; i < 5; i++)
    begin
      direct_pwm_mode = (i == 4);
      op(1'b1, 4'h1, 3'h0, {7'h00, 1'(i % 2), 2'(i > 3 ? 3 : i), 14'h0003}, 32);
      channel_output_pin = ~channel_output_pin ^ 8'($random(seed) & 8'hfe);
      period_len(3 * mt[i]);
    end
    $display("test period_timing done");
    op(1'b1, 4'h2, 3'h5, 24'hffffff, 31);
    cmp_cfg(32'(ferr), 32'h1);
    op(1'b0, 4'h2, 3'h5, 24'h000000, 32);
    chk;
    $display("test short_frame done");
    finish_test;
  end
endmodule
`default_nettype wire
